/* src/int_entry_nesting.sv */
// CPU interrupt entry, vector register and return-address stack.
// Assumes the core reports each retired instruction on pclk and an APB master.
`timescale 1ns/1ps
`include "int_entry_consts.svh"

module int_entry_nesting #(
  parameter int VW    = 8,
  parameter int AW    = 16,
  parameter int DEPTH = `STACK_DEPTH
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic [`LEVELS-1:0]         pi_req,
  input  wire logic [VW-1:0]              pi_vec,
  input  wire logic [`LEVELS-1:0]         em_req,
  input  wire logic [VW-1:0]              em_vec,
  input  wire logic                       nmi_req,
  input  wire logic                       instr_done,
  input  int_entry_pkg::instr_kind_t      instr_kind,
  input  wire logic [AW-1:0]              pc_next,
  input  wire logic [AW-1:0]              push_word,
  input  wire logic                       debug_active,
  output logic                            take_int,
  output logic      [AW-1:0]              vector_addr,
  output logic                            global_int_mask,
  output logic      [AW-1:0]              stack_top,
  output logic      [AW-1:0]              pop_word,
  output logic      [`CNT_W-1:0]          stack_level,
  output logic                            irq
);

  // ----------------------------------------------------------------
  // Request synchronisers and arrival delays
  // ----------------------------------------------------------------
  localparam int PW = VW + `LEVELS;
  logic [PW:0]  s1;
  logic [PW:0]  s2;
  logic [PW-1:0] s1e;
  logic [PW-1:0] s2e;
  logic [PW-1:0] pi_dl [`PI_SYNC_DLY];
  logic [PW-1:0] em_dl [`EM_SYNC_DLY];
  logic [`LEVELS-1:0] pi_q;
  logic [`LEVELS-1:0] em_q;
  logic         nmi_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1   <= '0;
      s2   <= '0;
      s1e  <= '0;
      s2e  <= '0;
      pi_q <= '0;
      em_q <= '0;
      nmi_q <= 1'b0;
      for (int i = 0; i < `PI_SYNC_DLY; i++) pi_dl[i] <= '0;
      for (int i = 0; i < `EM_SYNC_DLY; i++) em_dl[i] <= '0;
    end else begin
      s1   <= {nmi_req, pi_vec, pi_req};
      s2   <= s1;
      s1e  <= {em_vec, em_req};
      s2e  <= s1e;
      pi_dl[0] <= s2[PW-1:0];
      for (int i = 1; i < `PI_SYNC_DLY; i++) pi_dl[i] <= pi_dl[i-1];
      em_dl[0] <= s2e;
      for (int i = 1; i < `EM_SYNC_DLY; i++) em_dl[i] <= em_dl[i-1];
      pi_q  <= pi_dl[`PI_SYNC_DLY-1][`LEVELS-1:0];
      em_q  <= em_dl[`EM_SYNC_DLY-1][`LEVELS-1:0];
      nmi_q <= s2[PW];
    end
  end

  logic [`LEVELS-1:0] pi_out;
  logic [`LEVELS-1:0] em_out;
  logic [`LEVELS-1:0] pi_rise;
  logic [`LEVELS-1:0] em_rise;
  logic               nmi_rise;
  assign pi_out   = pi_dl[`PI_SYNC_DLY-1][`LEVELS-1:0];
  assign em_out   = em_dl[`EM_SYNC_DLY-1][`LEVELS-1:0];
  assign pi_rise  = pi_out & ~pi_q;
  assign em_rise  = em_out & ~em_q;
  assign nmi_rise = s2[PW] & ~nmi_q;

  // ----------------------------------------------------------------
  // Entry decision
  // ----------------------------------------------------------------
  function automatic logic [`LVL_W-1:0] pick(input logic [`LEVELS-1:0] v);
    pick = '0;
    for (int i = `LEVELS - 1; i >= 0; i--) begin
      if (v[i]) pick = `LVL_W'(i);
    end
  endfunction

  function automatic logic [AW-1:0] slot_of(input logic [`LVL_W-1:0] l);
    slot_of = AW'((32'(l) + 1) * `LVL_VEC_STEP);
  endfunction

  logic [`LEVELS-1:0] pend;
  logic [`LEVELS-1:0] level_mask;
  logic               nmi_pend;
  logic [VW-1:0]      vec_held [`LEVELS];
  logic [VW-1:0]      vreg;
  logic               vpend;
  logic [`LEVELS-1:0] avail;
  logic               boundary;
  logic               take_nmi;
  logic               take_mask;
  logic [`LVL_W-1:0]  lvl;
  logic [VW-1:0]      sel_vec;

  assign avail    = pend & level_mask;
  assign boundary = instr_done && (instr_kind == int_entry_pkg::plain_instr ||
                    instr_kind == int_entry_pkg::set_mask_instr);
  assign take_nmi  = boundary && nmi_pend;
  assign take_mask = boundary && !take_nmi && !global_int_mask && (|avail);
  assign lvl       = pick(avail);
  assign sel_vec   = vec_held[lvl];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic acc;
  logic rd_vec;
  logic rd_ists;
  logic bad;
  assign acc     = psel && penable;
  assign rd_vec  = acc && !pwrite && paddr == `OFS_VECTOR;
  assign rd_ists = acc && !pwrite && paddr == `OFS_IRQ_STATUS;
  assign bad     = !(paddr == `OFS_LEVEL_MASK || paddr == `OFS_PENDING ||
                     paddr == `OFS_VECTOR || paddr == `OFS_SYS_STATUS ||
                     paddr == `OFS_IRQ_STATUS || paddr == `OFS_IRQ_MASK);
  assign pready  = 1'b1;
  assign pslverr = acc && bad;

  // ----------------------------------------------------------------
  // Core state next values
  // ----------------------------------------------------------------
  logic [AW-1:0]      stk [DEPTH];
  logic [`CNT_W-1:0]  cnt;
  logic [`EV_W-1:0]   ists;
  logic [`EV_W-1:0]   imask;
  logic [`LEVELS-1:0] next_pend;
  logic               next_nmi_pend;
  logic [VW-1:0]      next_vec_held [`LEVELS];
  logic [VW-1:0]      next_vreg;
  logic               next_vpend;
  logic               next_global_int_mask;
  logic [AW-1:0]      next_vector_addr;
  logic [AW-1:0]      next_stk [DEPTH];
  logic [`CNT_W-1:0]  next_cnt;
  logic [`CNT_W-1:0]  limit;
  logic [AW-1:0]      next_pop_word;
  logic [`EV_W-1:0]   ev;
  logic [`EV_W-1:0]   next_ists;
  logic [`EV_W-1:0]   next_imask;
  logic [`LEVELS-1:0] next_level_mask;
  logic [31:0]        next_prdata;
  logic               do_pop;
  logic               do_push;
  logic [AW-1:0]      push_val;

  always_comb begin
    next_pend     = pend;
    next_nmi_pend = nmi_pend | nmi_rise;
    next_vec_held = vec_held;
    next_vreg     = vreg;
    next_global_int_mask     = global_int_mask;
    next_vector_addr = vector_addr;
    for (int i = 0; i < `LEVELS; i++) begin
      if (pi_rise[i]) next_vec_held[i] = pi_dl[`PI_SYNC_DLY-1][PW-1:`LEVELS];
      else if (em_rise[i]) next_vec_held[i] = em_dl[`EM_SYNC_DLY-1][PW-1:`LEVELS];
    end
    if (take_nmi) begin
      next_nmi_pend    = nmi_rise;
      next_global_int_mask        = 1'b1;
      next_vector_addr = `NMI_VEC;
    end else if (take_mask) begin
      next_pend[lvl]   = 1'b0;
      next_global_int_mask        = 1'b1;
      next_vreg        = sel_vec;
      next_vector_addr = slot_of(lvl);
    end else if (instr_done) begin
      if (instr_kind == int_entry_pkg::clear_control_bit_instr) next_global_int_mask = 1'b0;
      if (instr_kind == int_entry_pkg::set_mask_instr) next_global_int_mask = 1'b1;
    end
    next_pend  = next_pend | pi_rise | em_rise;
    next_vpend = take_mask | (vpend & ~rd_vec);
  end

  always_comb begin
    next_stk      = stk;
    next_cnt      = cnt;
    next_pop_word = pop_word;
    ev            = '0;
    limit         = debug_active ? `CNT_W'(DEPTH - 1) : `CNT_W'(DEPTH);
    do_pop  = instr_done && (instr_kind == int_entry_pkg::return_instr ||
              instr_kind == int_entry_pkg::pop_data_instr);
    do_push = take_nmi || take_mask || (instr_done &&
              (instr_kind == int_entry_pkg::call_instr ||
               instr_kind == int_entry_pkg::push_data_instr));
    push_val = (instr_done && instr_kind == int_entry_pkg::push_data_instr &&
                !take_nmi && !take_mask) ? push_word : pc_next;
    if (do_pop) begin
      next_pop_word = stk[0];
      for (int i = 0; i < DEPTH - 1; i++) next_stk[i] = stk[i+1];
      if (cnt == '0) ev[`EV_UNDERFLOW] = 1'b1;
      else next_cnt = cnt - 1'b1;
    end else if (do_push) begin
      next_stk[0] = push_val;
      for (int i = 1; i < DEPTH; i++) next_stk[i] = stk[i-1];
      if (cnt >= limit) ev[`EV_OVERFLOW] = 1'b1;
      else next_cnt = cnt + 1'b1;
    end
    ev[`EV_MASK_ENTRY] = take_mask;
    ev[`EV_NMI_ENTRY]  = take_nmi;
  end

  always_comb begin
    next_level_mask = level_mask;
    next_imask      = imask;
    next_prdata     = prdata;
    next_ists       = (rd_ists ? '0 : ists) | ev;
    if (acc && pwrite && paddr == `OFS_LEVEL_MASK) next_level_mask = pwdata[`LEVELS-1:0];
    if (acc && pwrite && paddr == `OFS_IRQ_MASK) next_imask = pwdata[`EV_W-1:0];
    if (psel && !penable && !pwrite) begin
      next_prdata = '0;
      case (paddr)
        `OFS_LEVEL_MASK: next_prdata[`LEVELS-1:0] = level_mask;
        `OFS_PENDING:    next_prdata[`LEVELS-1:0] = pend;
        `OFS_VECTOR:     next_prdata[VW-1:0]      = vreg;
        `OFS_SYS_STATUS: begin
          next_prdata[`SS_VPEND_BIT] = vpend;
          next_prdata[`SS_GLOBAL_INT_MASK_BIT]  = global_int_mask;
          next_prdata[`SS_NMI_BIT]   = nmi_pend;
          next_prdata[`SS_CNT_LSB +: `CNT_W] = cnt;
        end
        `OFS_IRQ_STATUS: next_prdata[`EV_W-1:0] = ists;
        `OFS_IRQ_MASK:   next_prdata[`EV_W-1:0] = imask;
        default:         next_prdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend            <= '0;
      nmi_pend        <= 1'b0;
      vreg            <= '0;
      vpend           <= 1'b0;
      global_int_mask <= `GLOBAL_INT_MASK_RESET;
      vector_addr     <= '0;
      take_int        <= 1'b0;
      cnt             <= '0;
      pop_word        <= '0;
      ists            <= '0;
      imask           <= '0;
      level_mask      <= '0;
      prdata          <= '0;
      for (int i = 0; i < `LEVELS; i++) vec_held[i] <= '0;
      for (int i = 0; i < DEPTH; i++) stk[i] <= '0;
    end else begin
      pend            <= next_pend;
      nmi_pend        <= next_nmi_pend;
      vreg            <= next_vreg;
      vpend           <= next_vpend;
      global_int_mask <= next_global_int_mask;
      vector_addr     <= next_vector_addr;
      take_int        <= take_nmi | take_mask;
      cnt             <= next_cnt;
      pop_word        <= next_pop_word;
      ists            <= next_ists;
      imask           <= next_imask;
      level_mask      <= next_level_mask;
      prdata          <= next_prdata;
      vec_held        <= next_vec_held;
      stk             <= next_stk;
    end
  end

  assign stack_top   = stk[0];
  assign stack_level = cnt;
  assign irq         = |(ists & imask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence em_arrive; $rose(s2e[0]); endsequence
  sequence pi_arrive; $rose(s2[0]); endsequence

  lvl_two_slot_a: assert property (take_mask && lvl == `LVL_W'(1) |=>
    take_int && vector_addr == slot_of(`LVL_W'(1))) else $error("level two slot wrong");
  lvl_one_slot_a: assert property (take_mask && lvl == '0 |=>
    take_int && vector_addr == slot_of('0)) else $error("level one slot wrong");
  nmi_slot_a: assert property (take_nmi |=> take_int && vector_addr == `NMI_VEC)
    else $error("nmi slot wrong");
  nmi_keeps_vec_a: assert property (take_nmi && !rd_vec |=>
    $stable(vreg) && $stable(vpend)) else $error("nmi altered vector register");
  vec_load_a: assert property (take_mask |=> vpend && vreg == $past(sel_vec))
    else $error("vector not loaded");
  push_pc_a: assert property (take_nmi || take_mask |=> stack_top == $past(pc_next))
    else $error("return address not pushed");
  depth_cap_a: assert property (debug_active && do_push && !do_pop &&
    cnt == `CNT_W'(DEPTH - 1) |=> cnt == `CNT_W'(DEPTH - 1)) else $error("debug entry used");
  unmask_shield_a: assert property (instr_done &&
    (instr_kind == int_entry_pkg::clear_control_bit_instr ||
     instr_kind == int_entry_pkg::return_instr) |=> !take_int) else $error("entry too early");
  push_data_a: assert property (instr_done && !take_nmi && !take_mask &&
    instr_kind == int_entry_pkg::push_data_instr |=> stack_top == $past(push_word))
    else $error("push data lost");
  em_delay_a: assert property (em_arrive |=> $rose(em_out[0]))
    else $error("event manager delay wrong");
  pi_delay_a: assert property (pi_arrive |-> ##4 $rose(pi_out[0]))
    else $error("peripheral delay wrong");
  vec_read_a: assert property (rd_vec && !take_mask |=> !vpend)
    else $error("vector read did not clear flag");

endmodule // int_entry_nesting

/* src/int_entry_consts.svh */
// Constants for the interrupt entry and nesting block.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef INT_ENTRY_CONSTS_SVH
`define INT_ENTRY_CONSTS_SVH

// ----------------------------------------------------------------
// Interrupt levels and vectors
// ----------------------------------------------------------------
`define LEVELS        6
`define LVL_W         3
`define LVL_VEC_STEP  2
`define NMI_VEC       16'h0024

// ----------------------------------------------------------------
// Synchronisation delays and stack
// ----------------------------------------------------------------
`define PI_SYNC_DLY   4
`define EM_SYNC_DLY   1
`define STACK_DEPTH   8
`define CNT_W         4

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_LEVEL_MASK 8'h00
`define OFS_PENDING    8'h04
`define OFS_VECTOR     8'h08
`define OFS_SYS_STATUS 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK   8'h14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SS_VPEND_BIT   0
`define SS_GLOBAL_INT_MASK_BIT    1
`define SS_NMI_BIT     2
`define SS_CNT_LSB     4
`define EV_W           4
`define EV_MASK_ENTRY  0
`define EV_NMI_ENTRY   1
`define EV_OVERFLOW    2
`define EV_UNDERFLOW   3
`define GLOBAL_INT_MASK_RESET     1'b1

`endif

/* src/int_entry_pkg.sv */
// Types shared by the interrupt entry block and its bench.
// Assumes nothing of its surroundings.
package int_entry_pkg;

  // ----------------------------------------------------------------
  // Kind of the instruction retiring in the current cycle
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    plain_instr             = 3'h0,
    clear_control_bit_instr = 3'h1,
    set_mask_instr          = 3'h2,
    return_instr            = 3'h3,
    call_instr              = 3'h4,
    push_data_instr         = 3'h5,
    pop_data_instr          = 3'h6
  } instr_kind_t;

endpackage

/* verif/req_source.sv */
// Request source model for the peripheral interface and the event manager.
// Assumes the bench pulses fire for one cycle with a source, a level and a vector.
`timescale 1ns/1ps

module req_source (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fire,
  input  wire logic [1:0] src,
  input  wire logic [2:0] lvl,
  input  wire logic [7:0] vec,
  output logic      [5:0] pi_req,
  output logic      [7:0] pi_vec,
  output logic      [5:0] em_req,
  output logic      [7:0] em_vec,
  output logic            nmi_req
);
  int hold;

  // A request stays up while its vector is held; then the vector lines change.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pi_req  <= '0;
      em_req  <= '0;
      nmi_req <= 1'b0;
      pi_vec  <= 8'h5A;
      em_vec  <= 8'hA5;
      hold    <= 0;
    end else if (fire) begin
      if (src == 2'h0) begin
        pi_req[lvl] <= 1'b1;
        pi_vec      <= vec;
        hold        <= 7;
      end else if (src == 2'h1) begin
        em_req[lvl] <= 1'b1;
        em_vec      <= vec;
        hold        <= 4;
      end else begin
        nmi_req <= 1'b1;
        hold    <= 3;
      end
    end else if (hold == 1) begin
      pi_req  <= '0;
      em_req  <= '0;
      nmi_req <= 1'b0;
      pi_vec  <= ~pi_vec;
      em_vec  <= ~em_vec;
      hold    <= 0;
    end else if (hold != 0) begin
      hold <= hold - 1;
    end
  end
endmodule // req_source

/* verif/test_int_entry_nesting.sv */
// Self-checking bench for the interrupt entry and nesting block.
// Assumes the design, its package, its constants header and the request source model.
`timescale 1ns/1ps
`include "int_entry_consts.svh"

module test_int_entry_nesting;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fire;
  logic [7:0]  paddr, pi_vec, em_vec, vec, va, vb;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [5:0]  pi_req, em_req;
  logic        nmi_req, instr_done, debug_active, take_int, global_int_mask, irq;
  logic [15:0] pc_next, push_word, vector_addr, stack_top, pop_word, pa, pn;
  logic [3:0]  stack_level;
  logic [1:0]  src;
  logic [2:0]  lvl;
  logic [15:0] words [9];
  int          error_cnt, n_tests, n_pi, n_em;
  int_entry_pkg::instr_kind_t instr_kind;

  int_entry_nesting u_int_entry_nesting (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pi_req(pi_req), .pi_vec(pi_vec), .em_req(em_req),
    .em_vec(em_vec), .nmi_req(nmi_req), .instr_done(instr_done), .instr_kind(instr_kind),
    .pc_next(pc_next), .push_word(push_word), .debug_active(debug_active),
    .take_int(take_int), .vector_addr(vector_addr), .global_int_mask(global_int_mask),
    .stack_top(stack_top), .pop_word(pop_word), .stack_level(stack_level), .irq(irq));
  req_source u_req_source (.pclk(pclk), .presetn(presetn), .fire(fire), .src(src),
    .lvl(lvl), .vec(vec), .pi_req(pi_req), .pi_vec(pi_vec), .em_req(em_req),
    .em_vec(em_vec), .nmi_req(nmi_req));

  // ----------------------------------------------------------------
  // Tasks and expectations
  // ----------------------------------------------------------------
  function automatic logic [15:0] slot(input int l);
    return 16'((l + 1) * 2);
  endfunction
  function automatic logic [31:0] ss(input logic vp, input logic [3:0] cnt);
    return {24'h0, cnt, 2'b00, 1'b1, vp};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic retire(input int_entry_pkg::instr_kind_t k, input logic [15:0] pc);
    @(posedge pclk);
    instr_done <= 1'b1;
    instr_kind <= k;
    pc_next <= pc;
    push_word <= pc;
    @(posedge pclk);
    instr_done <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic raise(input logic [1:0] s, input logic [2:0] l, input logic [7:0] v);
    @(posedge pclk);
    fire <= 1'b1;
    src <= s;
    lvl <= l;
    vec <= v;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask
  task automatic unmask_take(input logic [15:0] pc);
    retire(int_entry_pkg::clear_control_bit_instr, 16'h0);
    check("no entry after unmask", take_int, 1'b0);
    retire(int_entry_pkg::plain_instr, pc);
    check("entry taken", take_int, 1'b1);
    check("return address", stack_top, pc);
  endtask
  task automatic latency(input logic [1:0] s, input logic [2:0] l, output int n);
    retire(int_entry_pkg::clear_control_bit_instr, 16'h0);
    retire(int_entry_pkg::plain_instr, 16'h0);
    n = 0;
    @(posedge pclk);
    fire <= 1'b1;
    src <= s;
    lvl <= l;
    vec <= 8'($urandom);
    instr_done <= 1'b1;
    instr_kind <= int_entry_pkg::plain_instr;
    @(posedge pclk);
    fire <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (take_int !== 1'b1 && n < 40);
    instr_done <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    seed = $urandom(32'h59E66BA7);
    {presetn, psel, penable, pwrite, fire, instr_done, debug_active} = '0;
    {paddr, pwdata, pc_next, push_word, src, lvl, vec} = '0;
    instr_kind = int_entry_pkg::plain_instr;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("reset mask", global_int_mask, 1'b1);
    check("reset level", stack_level, 4'h0);
    check("ready", pready, 1'b1);
    apb(1'b0, `OFS_SYS_STATUS, 32'h0);
    check("reset status", rd, ss(1'b0, 4'h0));
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped err", err, 1'b1);
    apb(1'b1, `OFS_IRQ_MASK, $urandom);
    apb(1'b0, `OFS_IRQ_MASK, 32'h0);
    check("irq mask width", rd[31:4], 28'h0);
    apb(1'b1, `OFS_IRQ_MASK, 32'h1);
    apb(1'b1, `OFS_LEVEL_MASK, 32'hFFFFFFFF);
    apb(1'b0, `OFS_LEVEL_MASK, 32'h0);
    check("level mask", rd, 32'h3F);
    $display("test reset done");
    va = 8'($urandom);
    vb = 8'($urandom);
    pa = 16'($urandom);
    raise(2'h0, 3'h1, va);
    unmask_take(pa);
    check("level two slot", vector_addr, 16'h0004);
    check("one pushed", stack_level, 4'h1);
    check("irq high", irq, 1'b1);
    apb(1'b0, `OFS_SYS_STATUS, 32'h0);
    check("vector flag set", rd, ss(1'b1, 4'h1));
    raise(2'h1, 3'h0, vb);
    unmask_take(16'($urandom));
    check("level one slot", vector_addr, 16'h0002);
    apb(1'b0, `OFS_VECTOR, 32'h0);
    check("vector replaced", rd, {24'h0, vb});
    apb(1'b0, `OFS_SYS_STATUS, 32'h0);
    check("flag cleared", rd, ss(1'b0, 4'h2));
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("irq status", rd, 32'h1);
    check("irq low", irq, 1'b0);
    $display("test maskable entry done");
    raise(2'h0, 3'h2, va);
    unmask_take(16'($urandom));
    check("level three slot", vector_addr, slot(2));
    raise(2'h2, 3'h0, 8'h0);
    pn = 16'($urandom);
    retire(int_entry_pkg::plain_instr, pn);
    check("nmi taken", take_int, 1'b1);
    check("nmi slot", vector_addr, `NMI_VEC);
    apb(1'b0, `OFS_SYS_STATUS, 32'h0);
    check("flag kept by nmi", rd, ss(1'b1, 4'h4));
    apb(1'b0, `OFS_VECTOR, 32'h0);
    check("vector kept by nmi", rd, {24'h0, va});
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("irq status nmi", rd, 32'h3);
    $display("test nmi done");
    raise(2'h1, 3'h3, vb);
    retire(int_entry_pkg::clear_control_bit_instr, 16'h0);
    check("no entry after unmask", take_int, 1'b0);
    retire(int_entry_pkg::return_instr, 16'h0);
    check("no entry after return", take_int, 1'b0);
    check("popped first", pop_word, pn);
    check("level after pop", stack_level, 4'h3);
    pa = 16'($urandom);
    retire(int_entry_pkg::plain_instr, pa);
    check("entry after return", take_int, 1'b1);
    check("level four slot", vector_addr, slot(3));
    check("push after pop", stack_level, 4'h4);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    $display("test return nesting done");
    latency(2'h0, 3'h0, n_pi);
    latency(2'h1, 3'h5, n_em);
    check("sync delay gap", 32'(n_pi - n_em), 32'd3);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    $display("test latency done");
    repeat (6) retire(int_entry_pkg::pop_data_instr, 16'h0);
    check("stack empty", stack_level, 4'h0);
    for (int i = 0; i < 9; i++) begin
      words[i] = 16'($urandom);
      retire(int_entry_pkg::push_data_instr, words[i]);
    end
    check("stack full", stack_level, 4'h8);
    for (int i = 0; i < 8; i++) begin
      retire(int_entry_pkg::pop_data_instr, 16'h0);
      check("pop data", pop_word, words[8 - i]);
    end
    retire(int_entry_pkg::pop_data_instr, 16'h0);
    check("underflow level", stack_level, 4'h0);
    apb(1'b0, `OFS_IRQ_STATUS, 32'h0);
    check("over and underflow", rd, 32'hC);
    debug_active <= 1'b1;
    repeat (8) retire(int_entry_pkg::push_data_instr, 16'($urandom));
    check("debug reserve", stack_level, 4'h7);
    debug_active <= 1'b0;
    retire(int_entry_pkg::push_data_instr, 16'($urandom));
    check("reserve released", stack_level, 4'h8);
    retire(int_entry_pkg::call_instr, pa);
    check("call pushes", stack_top, pa);
    retire(int_entry_pkg::clear_control_bit_instr, 16'h0);
    check("unmasked", global_int_mask, 1'b0);
    retire(int_entry_pkg::set_mask_instr, 16'h0);
    check("masked again", global_int_mask, 1'b1);
    $display("test stack done");
    give_verdict();
  end
endmodule // test_int_entry_nesting
